// [tmc_pkg.sv]
package tmc_pkg;

    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 8;

    // Special-function register addresses.
    localparam logic [7:0]  ADDR_TIMER_CONTROL    = 8'h88;
    localparam logic [7:0]  ADDR_TIMER_MODE       = 8'h89;
    localparam logic [7:0]  ADDR_TIMER0_LOW       = 8'h8a;
    localparam logic [7:0]  ADDR_TIMER1_LOW       = 8'h8b;
    localparam logic [7:0]  ADDR_TIMER0_HIGH      = 8'h8c;
    localparam logic [7:0]  ADDR_TIMER1_HIGH      = 8'h8d;
    localparam logic [7:0]  ADDR_TIMER2_CONTROL   = 8'hc8;
    localparam logic [7:0]  ADDR_TIMER2_RELOAD_LO = 8'hca;
    localparam logic [7:0]  ADDR_TIMER2_RELOAD_HI = 8'hcb;
    localparam logic [7:0]  ADDR_TIMER2_COUNT_LO  = 8'hcc;
    localparam logic [7:0]  ADDR_TIMER2_COUNT_HI  = 8'hcd;

    // Bit positions inside the timer 0/1 control register.
    localparam int          T1_FLAG_BIT = 7;
    localparam int          T1_RUN_BIT  = 6;
    localparam int          T0_FLAG_BIT = 5;
    localparam int          T0_RUN_BIT  = 4;

    // Reset values.
    localparam logic [7:0]  RESET_BYTE  = 8'h00;
    localparam logic [15:0] RESET_WORD  = 16'h0000;
    localparam logic [3:0]  RESET_PINS  = 4'hf;

    // System clock cycles per internal timer tick.
    localparam int          TICK_DIV    = 12;

    typedef enum logic [1:0] {
        TMC_MODE_13BIT   = 2'b00,
        TMC_MODE_16BIT   = 2'b01,
        TMC_MODE_RELOAD8 = 2'b10,
        TMC_MODE_SPLIT8  = 2'b11
    } tmc_mode_e;

    typedef struct packed {
        logic      gate;
        logic      counter_select;
        tmc_mode_e mode;
    } tmc_tmode_s;

    typedef struct packed {
        logic timer2_overflow_flag;
        logic timer2_ext_edge_flag;
        logic uart_rx_clock_select;
        logic uart_tx_clock_select;
        logic timer2_ext_enable;
        logic timer2_run;
        logic timer2_counter_select;
        logic timer2_capture_reload_select;
    } tmc_t2ctl_s;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic       overflow;
    } tmc_step_s;

    typedef struct packed {
        logic count_lo;
        logic count_hi;
        logic reload_lo;
        logic reload_hi;
    } tmc_t2wr_s;

endpackage : tmc_pkg

// [tmc_tick_div.sv]
module tmc_tick_div #(
    parameter int DIV = tmc_pkg::TICK_DIV
) (
    input  wire logic clk,
    input  wire logic reset_n,
    output logic      tick_q
);

    logic [7:0] count_q;
    logic       wrap;

    // The divider runs free so that every timer shares one tick phase.
    assign wrap = (count_q == 8'(DIV - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= tmc_pkg::RESET_BYTE;
            tick_q  <= 1'b0;
        end else begin
            count_q <= wrap ? tmc_pkg::RESET_BYTE : count_q + 8'h01;
            tick_q  <= wrap;
        end
    end

endmodule : tmc_tick_div

// [tmc_timer2.sv]
module tmc_timer2 (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               tick,
    input  tmc_pkg::tmc_t2ctl_s     ctl,
    input  wire logic               count_fall,
    input  wire logic               ext_fall,
    input  tmc_pkg::tmc_t2wr_s      byte_write,
    input  wire logic [7:0]         wdata,
    output logic [15:0]             count_q,
    output logic [15:0]             reload_q,
    output logic                    overflow,
    output logic                    ext_event
);

    logic        baud;
    logic        step;
    logic        capture;
    logic        ext_reload;
    logic        reload_now;
    logic [15:0] count_next;
    logic [15:0] count_d;
    logic [15:0] reload_d;

    assign baud       = ctl.uart_rx_clock_select | ctl.uart_tx_clock_select;
    assign step       = ctl.timer2_run &
                        (ctl.timer2_counter_select ? count_fall : tick);
    assign overflow   = step & (count_q == 16'hffff);
    assign ext_event  = ctl.timer2_ext_enable & ext_fall;
    // Edges only capture or reload on a running timer so that a stopped count is never disturbed.
    assign capture    = ext_event & ctl.timer2_run & ctl.timer2_capture_reload_select
                        & ~baud;
    assign ext_reload = ext_event & ctl.timer2_run & ~ctl.timer2_capture_reload_select
                        & ~baud;
    assign reload_now = (overflow & (baud | ~ctl.timer2_capture_reload_select))
                        | ext_reload;

    assign count_next = reload_now ? reload_q : (step ? count_q + 16'h0001 : count_q);
    assign count_d    = byte_write.count_lo ? {count_next[15:8], wdata} :
                        byte_write.count_hi ? {wdata, count_next[7:0]} : count_next;
    assign reload_d   = byte_write.reload_lo ? {reload_q[15:8], wdata} :
                        byte_write.reload_hi ? {wdata, reload_q[7:0]} :
                        capture ? count_q : reload_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q  <= tmc_pkg::RESET_WORD;
            reload_q <= tmc_pkg::RESET_WORD;
        end else begin
            count_q  <= count_d;
            reload_q <= reload_d;
        end
    end

endmodule : tmc_timer2

// [tmc_top.sv]
// Overview of operation
// - Mode 0: low five bits prescale the high byte, thirteen bits total.
// - Mode 1: both bytes cascade into one sixteen-bit counter.
// - Mode 2: low byte counts, reloads from high byte on overflow.
// - Mode 3 exists for timer 0 only, splitting it into two byte counters.
// - Split mode: low byte uses timer 0 run/flag, high byte timer 1's.
// - Timer 2 reloads, captures, or generates the serial baud rate.
// - Timer 2 has five registers: count bytes, reload bytes, control.
// - Timer 2 control sits at c8 with the listed bit order.
// - Timer 2 overflow flag stays clear while either baud select is set.
// - Enabled falling capture edge sets the edge flag; software clears it.
// - Receive baud ticks come from timer 2 or timer 1 per select bit.
// - Transmit baud ticks come from timer 2 or timer 1 per select bit.
// - Capture input edges act only while the external enable is set.
// - Setting the timer 2 run bit starts it counting.
// - Capture select set: an enabled edge copies count into reload bytes; the code does so only while the timer 2 run bit is set.
// - Capture select clear: reload on overflow or enabled falling edge; the code reloads on an edge only while the run bit is set.
// - Auto-reload overflow sets the flag and reloads the count.
module tmc_top #(
    parameter int TICK_DIV = tmc_pkg::TICK_DIV
) (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic [tmc_pkg::ADDR_W-1:0] address,
    input  wire logic [tmc_pkg::DATA_W-1:0] write_data,
    input  wire logic                       write_strobe,
    input  wire logic                       read_strobe,
    output logic [tmc_pkg::DATA_W-1:0]      read_data,
    input  wire logic                       timer0_count_input,
    input  wire logic                       timer1_count_input,
    input  wire logic                       timer2_count_input,
    input  wire logic                       timer2_capture_reload_input,
    input  wire logic                       timer0_gate_input,
    input  wire logic                       timer1_gate_input,
    input  wire logic                       timer0_irq_ack,
    input  wire logic                       timer1_irq_ack,
    output logic                            timer0_overflow_flag,
    output logic                            timer1_overflow_flag,
    output logic                            timer2_overflow_flag,
    output logic                            timer2_ext_edge_flag,
    output logic                            serial_port_zero_rx_tick,
    output logic                            serial_port_zero_tx_tick
);

    function automatic tmc_pkg::tmc_step_s step_timer(
        input tmc_pkg::tmc_mode_e mode,
        input logic [7:0]         low,
        input logic [7:0]         high,
        input logic               inc
    );
        tmc_pkg::tmc_step_s r;
        logic [5:0]         pre;
        logic [8:0]         sum_low;
        logic [8:0]         sum_high;
        r.low      = low;
        r.high     = high;
        r.overflow = 1'b0;
        pre        = {1'b0, low[4:0]} + 6'h01;
        sum_low    = {1'b0, low} + 9'h001;
        sum_high   = {1'b0, high} + 9'h001;
        if (inc) begin
            unique case (mode)
                tmc_pkg::TMC_MODE_13BIT: begin
                    // The top three low-byte bits are left alone in this mode.
                    r.low = {low[7:5], pre[4:0]};
                    if (pre[5]) begin
                        r.high     = sum_high[7:0];
                        r.overflow = sum_high[8];
                    end
                end
                tmc_pkg::TMC_MODE_16BIT: begin
                    r.low = sum_low[7:0];
                    if (sum_low[8]) begin
                        r.high     = sum_high[7:0];
                        r.overflow = sum_high[8];
                    end
                end
                tmc_pkg::TMC_MODE_RELOAD8: begin
                    r.low      = sum_low[8] ? high : sum_low[7:0];
                    r.overflow = sum_low[8];
                end
                tmc_pkg::TMC_MODE_SPLIT8: begin
                    r.low      = sum_low[7:0];
                    r.overflow = sum_low[8];
                end
            endcase
        end
        return r;
    endfunction : step_timer

    // Registers.
    logic [7:0]          timer_mode_q;
    logic                timer0_run_q;
    logic                timer1_run_q;
    logic                timer0_flag_q;
    logic                timer1_flag_q;
    logic [7:0]          timer0_low_byte_q;
    logic [7:0]          timer0_high_byte_q;
    logic [7:0]          timer1_low_byte_q;
    logic [7:0]          timer1_high_byte_q;
    tmc_pkg::tmc_t2ctl_s timer2_control_config_q;
    logic [3:0]          pin_q;
    logic [7:0]          read_data_q;
    logic                rx_tick_q;
    logic                tx_tick_q;

    // Next values.
    logic [7:0]          timer0_low_byte_d;
    logic [7:0]          timer0_high_byte_d;
    logic [7:0]          timer1_low_byte_d;
    logic [7:0]          timer1_high_byte_d;
    logic                timer0_flag_d;
    logic                timer1_flag_d;
    tmc_pkg::tmc_t2ctl_s timer2_control_config_d;
    logic [7:0]          read_data_d;

    // Decode.
    logic                wr_control;
    logic                wr_mode;
    logic                wr_t0_low;
    logic                wr_t0_high;
    logic                wr_t1_low;
    logic                wr_t1_high;
    logic                wr_t2_control;
    tmc_pkg::tmc_t2wr_s  wr_t2_bytes;

    // Counting.
    tmc_pkg::tmc_tmode_s t0_cfg;
    tmc_pkg::tmc_tmode_s t1_cfg;
    logic                tick;
    logic [3:0]          pin_now;
    logic [3:0]          pin_fall;
    logic                t0_split;
    logic                t0_open;
    logic                t1_open;
    logic                t1_gate_ok;
    logic                t1_source;
    logic                t0_inc;
    logic                t1_inc;
    logic                th0_inc;
    logic [8:0]          th0_sum;
    logic                th0_overflow;
    tmc_pkg::tmc_step_s  t0_step;
    tmc_pkg::tmc_step_s  t1_step;
    logic                t0_flag_set;
    logic                t1_flag_set;
    logic                t1_baud_pulse;
    logic                t2_overflow;
    logic                t2_ext_event;
    logic                t2_baud;
    logic [15:0]         t2_count;
    logic [15:0]         t2_reload;

    tmc_tick_div #(
        .DIV     (TICK_DIV)
    ) u_tick_div (
        .clk     (clk),
        .reset_n (reset_n),
        .tick_q  (tick)
    );

    assign wr_control    = write_strobe & (address == tmc_pkg::ADDR_TIMER_CONTROL);
    assign wr_mode       = write_strobe & (address == tmc_pkg::ADDR_TIMER_MODE);
    assign wr_t0_low     = write_strobe & (address == tmc_pkg::ADDR_TIMER0_LOW);
    assign wr_t0_high    = write_strobe & (address == tmc_pkg::ADDR_TIMER0_HIGH);
    assign wr_t1_low     = write_strobe & (address == tmc_pkg::ADDR_TIMER1_LOW);
    assign wr_t1_high    = write_strobe & (address == tmc_pkg::ADDR_TIMER1_HIGH);
    assign wr_t2_control = write_strobe & (address == tmc_pkg::ADDR_TIMER2_CONTROL);
    assign wr_t2_bytes.count_lo  = write_strobe & (address == tmc_pkg::ADDR_TIMER2_COUNT_LO);
    assign wr_t2_bytes.count_hi  = write_strobe & (address == tmc_pkg::ADDR_TIMER2_COUNT_HI);
    assign wr_t2_bytes.reload_lo = write_strobe & (address == tmc_pkg::ADDR_TIMER2_RELOAD_LO);
    assign wr_t2_bytes.reload_hi = write_strobe & (address == tmc_pkg::ADDR_TIMER2_RELOAD_HI);

    // Pins are synchronous, so one stage of history is enough for edge detection.
    assign pin_now  = {timer2_capture_reload_input, timer2_count_input,
                       timer1_count_input, timer0_count_input};
    assign pin_fall = pin_q & ~pin_now;

    assign t0_cfg   = tmc_pkg::tmc_tmode_s'(timer_mode_q[3:0]);
    assign t1_cfg   = tmc_pkg::tmc_tmode_s'(timer_mode_q[7:4]);
    assign t0_split = (t0_cfg.mode == tmc_pkg::TMC_MODE_SPLIT8);

    assign t0_open    = timer0_run_q & (~t0_cfg.gate | timer0_gate_input);
    assign t1_gate_ok = ~t1_cfg.gate | timer1_gate_input;
    assign t1_open    = timer1_run_q & t1_gate_ok;
    assign t1_source  = t1_cfg.counter_select ? pin_fall[1] : tick;
    assign t0_inc     = t0_open & (t0_cfg.counter_select ? pin_fall[0] : tick);
    // With its run bit lent to the high byte of timer 0, timer 1 keeps running
    // as a baud source; a timer 1 set to mode 3 of its own simply holds.
    assign t1_inc     = (t1_cfg.mode != tmc_pkg::TMC_MODE_SPLIT8) & t1_source &
                        (t0_split ? t1_gate_ok : t1_open);
    assign th0_inc    = t0_split & t1_open & tick;

    assign t0_step = step_timer(t0_cfg.mode, timer0_low_byte_q, timer0_high_byte_q, t0_inc);
    assign t1_step = step_timer(t1_cfg.mode, timer1_low_byte_q, timer1_high_byte_q, t1_inc);

    assign th0_sum      = {1'b0, timer0_high_byte_q} + 9'h001;
    assign th0_overflow = th0_inc & th0_sum[8];

    assign t0_flag_set   = t0_step.overflow;
    assign t1_flag_set   = t0_split ? th0_overflow : t1_step.overflow;
    assign t1_baud_pulse = t1_step.overflow;

    // A software write to a count byte takes priority over a count in that cycle.
    assign timer0_low_byte_d  = wr_t0_low ? write_data : t0_step.low;
    assign timer0_high_byte_d = wr_t0_high ? write_data :
                                t0_split ? (th0_inc ? th0_sum[7:0] : timer0_high_byte_q) :
                                t0_step.high;
    assign timer1_low_byte_d  = wr_t1_low ? write_data : t1_step.low;
    assign timer1_high_byte_d = wr_t1_high ? write_data : t1_step.high;

    // A flag being set wins over a write or acknowledge that clears it.
    assign timer0_flag_d = t0_flag_set | (~timer0_irq_ack &
                           (wr_control ? write_data[tmc_pkg::T0_FLAG_BIT] : timer0_flag_q));
    assign timer1_flag_d = t1_flag_set | (~timer1_irq_ack &
                           (wr_control ? write_data[tmc_pkg::T1_FLAG_BIT] : timer1_flag_q));

    tmc_timer2 u_timer2 (
        .clk        (clk),
        .reset_n    (reset_n),
        .tick       (tick),
        .ctl        (timer2_control_config_q),
        .count_fall (pin_fall[2]),
        .ext_fall   (pin_fall[3]),
        .byte_write (wr_t2_bytes),
        .wdata      (write_data),
        .count_q    (t2_count),
        .reload_q   (t2_reload),
        .overflow   (t2_overflow),
        .ext_event  (t2_ext_event)
    );

    assign t2_baud = timer2_control_config_q.uart_rx_clock_select |
                     timer2_control_config_q.uart_tx_clock_select;

    // Timer 2 flags have no acknowledge input: only software clears them.
    assign timer2_control_config_d.timer2_overflow_flag = (t2_overflow & ~t2_baud) |
        (wr_t2_control ? write_data[7] : timer2_control_config_q.timer2_overflow_flag);
    assign timer2_control_config_d.timer2_ext_edge_flag = t2_ext_event |
        (wr_t2_control ? write_data[6] : timer2_control_config_q.timer2_ext_edge_flag);
    assign timer2_control_config_d[5:0] = wr_t2_control ? write_data[5:0] :
                                          timer2_control_config_q[5:0];

    assign read_data_d =
        !read_strobe ? tmc_pkg::RESET_BYTE :
        (address == tmc_pkg::ADDR_TIMER_CONTROL)    ? {timer1_flag_q, timer1_run_q,
                                                       timer0_flag_q, timer0_run_q, 4'h0} :
        (address == tmc_pkg::ADDR_TIMER_MODE)       ? timer_mode_q :
        (address == tmc_pkg::ADDR_TIMER0_LOW)       ? timer0_low_byte_q :
        (address == tmc_pkg::ADDR_TIMER0_HIGH)      ? timer0_high_byte_q :
        (address == tmc_pkg::ADDR_TIMER1_LOW)       ? timer1_low_byte_q :
        (address == tmc_pkg::ADDR_TIMER1_HIGH)      ? timer1_high_byte_q :
        (address == tmc_pkg::ADDR_TIMER2_CONTROL)   ? timer2_control_config_q :
        (address == tmc_pkg::ADDR_TIMER2_RELOAD_LO) ? t2_reload[7:0] :
        (address == tmc_pkg::ADDR_TIMER2_RELOAD_HI) ? t2_reload[15:8] :
        (address == tmc_pkg::ADDR_TIMER2_COUNT_LO)  ? t2_count[7:0] :
        (address == tmc_pkg::ADDR_TIMER2_COUNT_HI)  ? t2_count[15:8] :
        tmc_pkg::RESET_BYTE;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_mode_q       <= tmc_pkg::RESET_BYTE;
            timer0_run_q       <= 1'b0;
            timer1_run_q       <= 1'b0;
            timer0_flag_q      <= 1'b0;
            timer1_flag_q      <= 1'b0;
            timer0_low_byte_q  <= tmc_pkg::RESET_BYTE;
            timer0_high_byte_q <= tmc_pkg::RESET_BYTE;
            timer1_low_byte_q  <= tmc_pkg::RESET_BYTE;
            timer1_high_byte_q <= tmc_pkg::RESET_BYTE;
        end else begin
            if (wr_mode) begin
                timer_mode_q <= write_data;
            end
            if (wr_control) begin
                timer0_run_q <= write_data[tmc_pkg::T0_RUN_BIT];
                timer1_run_q <= write_data[tmc_pkg::T1_RUN_BIT];
            end
            timer0_flag_q      <= timer0_flag_d;
            timer1_flag_q      <= timer1_flag_d;
            timer0_low_byte_q  <= timer0_low_byte_d;
            timer0_high_byte_q <= timer0_high_byte_d;
            timer1_low_byte_q  <= timer1_low_byte_d;
            timer1_high_byte_q <= timer1_high_byte_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer2_control_config_q <= tmc_pkg::tmc_t2ctl_s'(tmc_pkg::RESET_BYTE);
            pin_q                   <= tmc_pkg::RESET_PINS;
            read_data_q             <= tmc_pkg::RESET_BYTE;
            rx_tick_q               <= 1'b0;
            tx_tick_q               <= 1'b0;
        end else begin
            timer2_control_config_q <= timer2_control_config_d;
            pin_q                   <= pin_now;
            read_data_q             <= read_data_d;
            rx_tick_q <= timer2_control_config_q.uart_rx_clock_select ?
                         t2_overflow : t1_baud_pulse;
            tx_tick_q <= timer2_control_config_q.uart_tx_clock_select ?
                         t2_overflow : t1_baud_pulse;
        end
    end

    assign read_data                = read_data_q;
    assign timer0_overflow_flag     = timer0_flag_q;
    assign timer1_overflow_flag     = timer1_flag_q;
    assign timer2_overflow_flag     = timer2_control_config_q.timer2_overflow_flag;
    assign timer2_ext_edge_flag     = timer2_control_config_q.timer2_ext_edge_flag;
    assign serial_port_zero_rx_tick = rx_tick_q;
    assign serial_port_zero_tx_tick = tx_tick_q;

endmodule : tmc_top

// [tmc_props.sv]
module tmc_props (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] address,
    input wire logic [7:0] write_data,
    input wire logic       write_strobe,
    input wire logic       read_strobe,
    input wire logic [7:0] read_data,
    input wire logic       timer2_capture_reload_input,
    input wire logic       timer1_irq_ack,
    input wire logic       timer1_overflow_flag,
    input wire logic       timer2_overflow_flag,
    input wire logic       timer2_ext_edge_flag
);
    logic [5:0] ctl_q;
    wire        wr_c8 = write_strobe && address == 8'hc8;
    wire        wr_88 = write_strobe && address == 8'h88;
    // Only the software-owned bits can be shadowed, since the flags move by themselves.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) ctl_q <= 6'h00;
        else if (wr_c8) ctl_q <= write_data[5:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_enabled_fall;
        ctl_q[3] && $fell(timer2_capture_reload_input) && !wr_c8;
    endsequence
    chk_read_idle_zero: assert property (
        !$past(read_strobe) |-> read_data == 8'h00) else $error("read data outside a read");
    chk_unmapped_read: assert property (
        $past(read_strobe) && $past(address) == 8'h00 |-> read_data == 8'h00)
        else $error("unmapped read not zero");
    chk_t2_flag_baud: assert property (
        (ctl_q[5] || ctl_q[4]) && !wr_c8 |=> !$rose(timer2_overflow_flag))
        else $error("overflow flag set in baud mode");
    chk_t2_flag_hold: assert property (
        timer2_overflow_flag && !wr_c8 |=> timer2_overflow_flag) else $error("overflow flag lost");
    chk_edge_flag_hold: assert property (
        timer2_ext_edge_flag && !wr_c8 |=> timer2_ext_edge_flag) else $error("edge flag lost");
    chk_edge_flag_set: assert property (
        s_enabled_fall |=> timer2_ext_edge_flag) else $error("edge flag not set");
    chk_edge_ignored: assert property (
        !ctl_q[3] && !wr_c8 |=> !$rose(timer2_ext_edge_flag)) else $error("disabled edge flagged");
    chk_t1_flag_hold: assert property (
        timer1_overflow_flag && !timer1_irq_ack && !wr_88 |=> timer1_overflow_flag)
        else $error("timer 1 flag lost");
endmodule : tmc_props
bind tmc_top tmc_props u_props (.*);

// [tmc_pin_model.sv]
module tmc_pin_model (
    input  wire logic clk,
    input  wire logic make_edge,
    input  wire logic rx_tick,
    input  wire logic tx_tick,
    output logic      cap_pin,
    output logic      toggle_q,
    output int        rx_n,
    output int        tx_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] low_q = 2'd0;
    initial begin
        toggle_q = 1'b0;
        rx_n = 0;
        tx_n = 0;
    end
    // The capture pin idles high and is pulled low for two cycles per requested edge.
    always @(posedge clk) begin
        toggle_q <= !toggle_q;
        rx_n <= rx_n + int'(rx_tick);
        tx_n <= tx_n + int'(tx_tick);
        low_q <= make_edge ? 2'd2 : low_q - 2'(low_q != 2'd0);
    end
    assign cap_pin = low_q == 2'd0;
endmodule : tmc_pin_model

// [tmc_top_tb.sv]
module tmc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk = 0, reset_n = 0, write_strobe = 0, read_strobe = 0, make_edge = 0;
    logic [7:0] address = 8'h00, write_data = 8'h00, read_data;
    logic       timer0_gate_input = 0, timer1_gate_input = 1;
    logic       timer0_irq_ack = 0, timer1_irq_ack = 0, timer2_count_input = 1;
    logic       timer0_count_input, timer2_capture_reload_input, serial_port_zero_rx_tick;
    logic       serial_port_zero_tx_tick, timer0_overflow_flag, timer1_overflow_flag;
    logic       timer2_overflow_flag, timer2_ext_edge_flag;
    wire        timer1_count_input = timer0_count_input;
    int         n_errors = 0, n_compared = 0, rx_n, tx_n, rx0, tx0;
    logic [55:0] r;
    logic [55:0] rows [5] = '{56'h00_ff_05_10_e0_06_00, 56'h01_ff_ff_10_00_00_20,
        56'h02_ff_a5_10_a5_a5_20, 56'h03_10_ff_40_10_00_80, 56'h09_ff_ff_10_ff_ff_00};
    tmc_top #(.TICK_DIV(1)) i_dut (.*);
    tmc_pin_model i_pins (.clk(clk), .make_edge(make_edge), .rx_tick(serial_port_zero_rx_tick),
        .tx_tick(serial_port_zero_tx_tick), .cap_pin(timer2_capture_reload_input),
        .toggle_q(timer0_count_input), .rx_n(rx_n), .tx_n(tx_n));
    initial forever #12.5 clk = ~clk;
    task chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // Strobes stay up until the next call lowers them, so no edge sees a double assignment.
    task wr(input logic [7:0] a, input logic [7:0] d);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        read_strobe <= 1'b0;
        @(posedge clk);
        #1;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        address <= a;
        write_strobe <= 1'b0;
        read_strobe <= 1'b1;
        @(posedge clk);
        #1;
        chk(read_data, e);
    endtask : rd
    task idle(input int n);
        write_strobe <= 1'b0;
        read_strobe <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task pulse;
        make_edge <= 1'b1;
        idle(1);
        make_edge <= 1'b0;
        idle(5);
    endtask : pulse
    task baud(input logic [7:0] c, input logic [7:0] etx);
        wr(8'hc8, c);
        idle(2);
        rx0 = rx_n;
        tx0 = tx_n;
        idle(8);
        chk(8'(rx_n - rx0), 8'h08);
        chk(8'(tx_n - tx0), etx);
        chk(8'(timer2_overflow_flag), 8'h00);
    endtask : baud
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        rd(8'hc8, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'hc8, 8'h3b);
        rd(8'hc8, 8'h3b);
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            wr(8'h89, r[55:48]);
            wr(8'h8a, r[47:40]);
            wr(8'h8c, r[39:32]);
            wr(8'h88, r[31:24]);
            wr(8'h88, 8'h00);
            rd(8'h8a, r[23:16]);
            rd(8'h8c, r[15:8]);
            rd(8'h88, r[7:0]);
        end
        $display("timer 0 and 1 modes done");
        wr(8'hca, 8'h34);
        wr(8'hcb, 8'h12);
        wr(8'hcc, 8'hff);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h04);
        wr(8'hc8, 8'h00);
        rd(8'hcc, 8'h34);
        rd(8'hc8, 8'h80);
        idle(4);
        rd(8'hcd, 8'h12);
        wr(8'hcc, 8'h77);
        wr(8'hcd, 8'h00);
        wr(8'hca, 8'h55);
        wr(8'hc8, 8'h06);
        pulse();
        rd(8'hca, 8'h55);
        rd(8'hc8, 8'h06);
        wr(8'hc8, 8'h0f);
        pulse();
        rd(8'hca, 8'h77);
        rd(8'hc8, 8'h4f);
        wr(8'hca, 8'h34);
        wr(8'hcb, 8'h12);
        wr(8'hc8, 8'h00);
        rd(8'hc8, 8'h00);
        wr(8'hc8, 8'h0e);
        pulse();
        rd(8'hcc, 8'h34);
        rd(8'hcd, 8'h12);
        $display("timer 2 functions done");
        wr(8'hca, 8'hff);
        wr(8'hcb, 8'hff);
        wr(8'hcc, 8'hff);
        wr(8'hcd, 8'hff);
        baud(8'h34, 8'h08);
        baud(8'h24, 8'h00);
        wr(8'hc8, 8'h00);
        idle(1);
        $display("baud selection done");
        give_verdict();
    end
endmodule : tmc_top_tb
